/* verilog/dsc_params.svh */
// constants for the software command and channel control decoder
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH

`define DSC_SWCMD_ID        3'h4
`define DSC_ID_MSB          15
`define DSC_ID_LSB          13
`define DSC_USER_BIT        12
`define DSC_CODE_MSB        11
`define DSC_CODE_LSB        0
`define DSC_RESET_CODE      12'h555
`define DSC_KEEPALIVE_CODE  12'h195
`define DSC_STATUS_USER_BIT 11
`define DSC_RANGE_RST       3'h0
`define DSC_OVR_RST         1'b0
`define DSC_OVR_PERCENT     20
`define DSC_CLK_PERIOD_NS   10
`define DSC_WD_TIMEOUT_NS   5000000
`define DSC_WD_TIMEOUT_CYC  (`DSC_WD_TIMEOUT_NS / `DSC_CLK_PERIOD_NS)

`endif

/* verilog/dsc_pkg.sv */
// types for the software command and channel control decoder
package dsc_pkg;

   typedef enum logic [2:0]
   {
      DSC_V_0_5    = 3'h0,
      DSC_V_0_10   = 3'h1,
      DSC_V_PM5    = 3'h2,
      DSC_V_PM10   = 3'h3,
      DSC_I_4_20   = 3'h4,
      DSC_I_0_20   = 3'h5,
      DSC_I_0_24   = 3'h6,
      DSC_RSVD     = 3'h7
   } dsc_range_t;

   // per-channel control fields, range in the low bits
   typedef struct packed
   {
      logic       overrange_enable;
      dsc_range_t range_select;
   } dsc_chan_cfg_t;

   // one serial word laid out as a software command
   typedef struct packed
   {
      logic [2:0]  id;
      logic        user;
      logic [11:0] code;
   } dsc_swcmd_t;

endpackage : dsc_pkg

/* verilog/dsc_decoder.sv */
// decoder for channel range/overrange and the software command register
//
// Behaviour
// - per-channel overrange bit, reset disabled
// - overrange extends voltage ranges only, 20 percent
// - range codes 100-110 select current ranges
// - top bits 100 mark software command word
// - bit D12 of any command word except code 0x555 mirrors into status bit D11
// - code 0x555 performs full software reset
// - missed keep-alive raises alert when watchdog enabled
`timescale 1ns/1ps
`include "dsc_params.svh"

module dsc_decoder
#(
   parameter int NUM_CH      = 4,
   parameter int TIMEOUT_CYC = `DSC_WD_TIMEOUT_CYC
)
(
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  sw_wr_i,
   input  wire dsc_pkg::dsc_swcmd_t   sw_word_i,
   input  wire logic                  ch_wr_i,
   input  wire logic [1:0]            ch_sel_i,
   input  wire dsc_pkg::dsc_chan_cfg_t ch_cfg_i,
   input  wire logic                  wd_en_i,
   output logic [NUM_CH*4-1:0]        ch_cfg_o,
   output logic [NUM_CH-1:0]          is_current_o,
   output logic [NUM_CH-1:0]          ovr_active_o,
   output logic [15:0]                status_o,
   output logic                       sw_reset_o,
   output logic                       alert_o
);

   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYC - 1);

   dsc_pkg::dsc_chan_cfg_t cfg_ff     [NUM_CH];
   dsc_pkg::dsc_chan_cfg_t nxt_cfg    [NUM_CH];
   logic [NUM_CH*4-1:0]    nxt_cfg_o;
   logic [NUM_CH-1:0]      nxt_is_current;
   logic [NUM_CH-1:0]      nxt_ovr_active;
   logic                   user_ff;
   logic                   nxt_user;
   logic                   rst_pulse_ff;
   logic                   nxt_rst_pulse;
   logic [CW-1:0]          wd_cnt_ff;
   logic [CW-1:0]          nxt_wd_cnt;
   logic                   alert_ff;
   logic                   nxt_alert;
   logic                   is_sw;
   logic                   is_reset;
   logic                   is_keep;

   assign is_sw    = sw_wr_i && (sw_word_i.id == `DSC_SWCMD_ID);
   assign is_reset = is_sw && (sw_word_i.code == `DSC_RESET_CODE);
   assign is_keep  = is_sw && (sw_word_i.code == `DSC_KEEPALIVE_CODE);

   // channel configuration and its registered decode
   always_comb
   begin
      nxt_cfg_o      = '0;
      nxt_is_current = '0;
      nxt_ovr_active = '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         nxt_cfg[i] = cfg_ff[i];
         if (is_reset)
         begin
            nxt_cfg[i].overrange_enable = `DSC_OVR_RST;
            nxt_cfg[i].range_select     = dsc_pkg::dsc_range_t'(`DSC_RANGE_RST);
         end
         else if (ch_wr_i && (ch_sel_i == 2'(i)))
         begin
            nxt_cfg[i] = ch_cfg_i;
         end
         case (nxt_cfg[i].range_select)
            dsc_pkg::DSC_I_4_20,
            dsc_pkg::DSC_I_0_20,
            dsc_pkg::DSC_I_0_24:
            begin
               nxt_is_current[i] = 1'b1;
            end
            dsc_pkg::DSC_V_0_5,
            dsc_pkg::DSC_V_0_10,
            dsc_pkg::DSC_V_PM5,
            dsc_pkg::DSC_V_PM10:
            begin
               // the analog stage adds the 20 percent span
               nxt_ovr_active[i] = nxt_cfg[i].overrange_enable;
            end
            default:
            begin
               // reserved code drives neither a current nor a voltage range
               nxt_is_current[i] = 1'b0;
            end
         endcase
         nxt_cfg_o[i*4 +: 4] = nxt_cfg[i];
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            cfg_ff[i] <= '0;
         end
         ch_cfg_o     <= '0;
         is_current_o <= '0;
         ovr_active_o <= '0;
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            cfg_ff[i] <= nxt_cfg[i];
         end
         ch_cfg_o     <= nxt_cfg_o;
         is_current_o <= nxt_is_current;
         ovr_active_o <= nxt_ovr_active;
      end
   end

   // software command: mirror bit, reset pulse, watchdog
   always_comb
   begin
      nxt_user      = user_ff;
      nxt_rst_pulse = is_reset;
      nxt_wd_cnt    = wd_cnt_ff;
      nxt_alert     = alert_ff;
      if (is_sw)
      begin
         nxt_user = sw_word_i.user;
      end
      if (is_reset)
      begin
         // a full reset also clears the mirror it would have written
         nxt_user   = 1'b0;
         nxt_wd_cnt = '0;
         nxt_alert  = 1'b0;
      end
      else if (!wd_en_i)
      begin
         nxt_wd_cnt = '0;
         nxt_alert  = 1'b0;
      end
      else if (is_keep)
      begin
         nxt_wd_cnt = '0;
         nxt_alert  = 1'b0;
      end
      else if (wd_cnt_ff == CNT_LAST)
      begin
         // alert holds until a keep-alive, reset or disable
         nxt_alert = 1'b1;
      end
      else
      begin
         nxt_wd_cnt = wd_cnt_ff + CW'(1);
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         user_ff      <= 1'b0;
         rst_pulse_ff <= 1'b0;
         wd_cnt_ff    <= '0;
         alert_ff     <= 1'b0;
         status_o     <= '0;
         sw_reset_o   <= 1'b0;
         alert_o      <= 1'b0;
      end
      else
      begin
         user_ff      <= nxt_user;
         rst_pulse_ff <= nxt_rst_pulse;
         wd_cnt_ff    <= nxt_wd_cnt;
         alert_ff     <= nxt_alert;
         status_o     <= 16'(nxt_user) << `DSC_STATUS_USER_BIT;
         sw_reset_o   <= nxt_rst_pulse;
         alert_o      <= nxt_alert;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_reset_wr;
      is_reset;
   endsequence

   sequence s_pulse_once;
      sw_reset_o ##1 !sw_reset_o;
   endsequence

   // a back-to-back reset code legally stretches the pulse, so skip that case
   a_reset_pulse: assert property (
      (s_reset_wr ##1 !is_reset) |-> s_pulse_once)
      else $error("reset code did not give a single reset pulse");

   a_reset_clears_cfg: assert property (sw_reset_o |-> ch_cfg_o == '0)
      else $error("channel config not cleared by software reset");

   a_mirror_copy: assert property ((is_sw && !is_reset)
      |=> status_o[`DSC_STATUS_USER_BIT] == $past(sw_word_i.user))
      else $error("status bit does not mirror the user bit");

   a_id_gate: assert property ((sw_wr_i && sw_word_i.id != `DSC_SWCMD_ID)
      |=> $stable(status_o) || $past(is_sw))
      else $error("non-command word changed the mirror bit");

   a_current_no_ovr: assert property (
      is_current_o[0] |-> !ovr_active_o[0])
      else $error("overrange active on a current range");

   a_volt_ovr: assert property ((ch_wr_i && ch_sel_i == 2'h0 && !is_reset
      && ch_cfg_i.overrange_enable && !ch_cfg_i.range_select[2])
      |=> ovr_active_o[0] && !is_current_o[0])
      else $error("voltage range with overrange not decoded");

   a_range_current: assert property ((ch_wr_i && ch_sel_i == 2'h1
      && !is_reset && ch_cfg_i.range_select == dsc_pkg::DSC_I_4_20)
      |=> is_current_o[1])
      else $error("current range code not decoded");

   a_keep_clears: assert property ((is_keep && wd_en_i)
      |=> !alert_o && wd_cnt_ff == '0)
      else $error("keep-alive did not restart the watchdog");

   a_alert_timeout: assert property ((wd_en_i && !is_keep && !is_reset
      && wd_cnt_ff == CNT_LAST) |=> alert_o)
      else $error("watchdog timeout did not raise alert");

   a_alert_off: assert property (!wd_en_i |=> !alert_o)
      else $error("alert raised with watchdog disabled");

   a_other_code: assert property ((is_sw && !is_keep && !is_reset
      && wd_en_i && wd_cnt_ff != CNT_LAST)
      |=> wd_cnt_ff == $past(wd_cnt_ff) + CW'(1))
      else $error("other code restarted the watchdog");

endmodule : dsc_decoder

/* testbench/dsc_host_model.sv */
// host side model that drives the decoder's command inputs
`timescale 1ns/1ps
module dsc_host_model
(
   input  wire logic              clk_i,
   output logic                   sw_wr_o,
   output dsc_pkg::dsc_swcmd_t    sw_word_o,
   output logic                   ch_wr_o,
   output logic [1:0]             ch_sel_o,
   output dsc_pkg::dsc_chan_cfg_t ch_cfg_o,
   output logic                   wd_en_o
);
   initial
   begin
      sw_wr_o   = 1'b0;
      sw_word_o = 16'h0000;
      ch_wr_o   = 1'b0;
      ch_sel_o  = 2'h0;
      ch_cfg_o  = 4'h0;
      wd_en_o   = 1'b0;
   end

   // data is scrambled after the strobe so stale values never look valid
   task automatic sw_cmd(input logic [2:0] id, input logic usr,
                         input logic [11:0] code);
      @(negedge clk_i);
      sw_word_o = {id, usr, code};
      sw_wr_o   = 1'b1;
      @(negedge clk_i);
      sw_wr_o   = 1'b0;
      sw_word_o = ~sw_word_o;
   endtask : sw_cmd

   task automatic keep_alive();
      sw_cmd(3'h4, 1'b0, 12'h195);
   endtask : keep_alive

   task automatic ch_write(input logic [1:0] sel, input logic [3:0] cfg);
      @(negedge clk_i);
      ch_sel_o = sel;
      ch_cfg_o = cfg;
      ch_wr_o  = 1'b1;
      @(negedge clk_i);
      ch_wr_o  = 1'b0;
      ch_cfg_o = ~cfg;
   endtask : ch_write

   task automatic set_wd(input logic en);
      @(negedge clk_i);
      wd_en_o = en;
   endtask : set_wd
endmodule : dsc_host_model

/* testbench/dsc_decoder_tb.sv */
// self-checking bench for the command decoder
`timescale 1ns/1ps
module dsc_decoder_tb;
   localparam int TO = 16;
   logic                   clk_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic                   sw_wr, ch_wr, wd_en, sw_reset, alert;
   dsc_pkg::dsc_swcmd_t    sw_word;
   dsc_pkg::dsc_chan_cfg_t ch_cfg;
   logic [1:0]             ch_sel;
   logic [15:0]            cfg_o, status;
   logic [3:0]             is_cur, ovr;
   int                     errors = 0;
   int                     tests_run = 0;
   int                     cycles = 0;

   always #5 clk_i = ~clk_i;

   dsc_host_model i_dsc_host_model (.clk_i(clk_i), .sw_wr_o(sw_wr),
      .sw_word_o(sw_word), .ch_wr_o(ch_wr), .ch_sel_o(ch_sel),
      .ch_cfg_o(ch_cfg), .wd_en_o(wd_en));

   dsc_decoder #(.NUM_CH(4), .TIMEOUT_CYC(TO)) i_dsc_decoder (.clk_i(clk_i),
      .rst_i(rst_i), .sw_wr_i(sw_wr), .sw_word_i(sw_word), .ch_wr_i(ch_wr),
      .ch_sel_i(ch_sel), .ch_cfg_i(ch_cfg), .wd_en_i(wd_en),
      .ch_cfg_o(cfg_o), .is_current_o(is_cur), .ovr_active_o(ovr),
      .status_o(status), .sw_reset_o(sw_reset), .alert_o(alert));

   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // generous ceiling: the whole sequence needs about 150 cycles
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      check("cfg_rst", cfg_o, 16'h0000);
      check("status_rst", status, 16'h0000);
      for (int ch = 0; ch < 4; ch++)
         for (int cd = 0; cd < 8; cd++)
         begin
            i_dsc_host_model.ch_write(ch[1:0], {1'b1, cd[2:0]});
            check("cfg", cfg_o[4*ch+:4], {1'b1, cd[2:0]});
            check("is_cur", is_cur[ch], cd >= 4 && cd <= 6);
            check("ovr", ovr[ch], cd < 4);
         end
      i_dsc_host_model.ch_write(2'h2, 4'h1);
      check("ovr_off", ovr[2], 1'b0);
      i_dsc_host_model.sw_cmd(3'h4, 1'b1, 12'h000);
      check("mirror_set", status, 16'h0800);
      i_dsc_host_model.sw_cmd(3'h5, 1'b0, 12'h000);
      check("wrong_id", status, 16'h0800);
      i_dsc_host_model.sw_cmd(3'h4, 1'b0, 12'h123);
      check("mirror_clr", status, 16'h0000);
      i_dsc_host_model.sw_cmd(3'h4, 1'b1, 12'h555);
      check("sw_reset", sw_reset, 1'b1);
      check("reset_cfg", cfg_o, 16'h0000);
      check("reset_status", status, 16'h0000);
      @(negedge clk_i);
      check("reset_pulse", sw_reset, 1'b0);
      i_dsc_host_model.set_wd(1'b1);
      i_dsc_host_model.keep_alive();
      repeat (TO - 5) @(negedge clk_i);
      i_dsc_host_model.sw_cmd(3'h4, 1'b1, 12'h196);
      check("other_code_st", status, 16'h0800);
      check("other_code_rst", sw_reset, 1'b0);
      repeat (2) @(negedge clk_i);
      check("alert_early", alert, 1'b0);
      @(negedge clk_i);
      check("alert_due", alert, 1'b1);
      i_dsc_host_model.keep_alive();
      check("alert_clr", alert, 1'b0);
      repeat (TO) @(negedge clk_i);
      check("alert_again", alert, 1'b1);
      i_dsc_host_model.set_wd(1'b0);
      @(negedge clk_i);
      check("wd_off_clr", alert, 1'b0);
      repeat (TO + 4) @(negedge clk_i);
      check("wd_off", alert, 1'b0);
      tally_and_finish();
   end
endmodule : dsc_decoder_tb
